/* File: logic/cor_pkg.sv */
// charger option register group: offsets, reset values, field positions, timing
// assumes a 10 MHz core clock and an APB slave with 32-bit data
package cor_pkg;
   // =====================================================
   // register indices; byte address is four times the index
   localparam logic [7:0] COR_IDX_OPT2_LOW = 8'h32;
   localparam logic [7:0] COR_IDX_OPT2_HIGH = 8'h33;
   localparam logic [7:0] COR_IDX_OPT3_LOW = 8'h34;
   localparam logic [7:0] COR_IDX_OPT3_HIGH = 8'h35;
   localparam logic [7:0] COR_IDX_IRQ_STATUS = 8'h40;
   localparam logic [7:0] COR_IDX_IRQ_MASK = 8'h41;
   // =====================================================
   // values after reset
   localparam logic [7:0] COR_RST_OPT2_LOW = 8'hB7;
   localparam logic [7:0] COR_RST_OPT2_HIGH = 8'h02;
   localparam logic [7:0] COR_RST_OPT3_LOW = 8'h30;
   localparam logic [7:0] COR_RST_OPT3_HIGH = 8'h00;
   // reserved bits hold their reset value; peak status bits are hardware owned
   localparam logic [7:0] COR_RSVD_OPT2_LOW = 8'h10;
   localparam logic [7:0] COR_RSVD_OPT3_LOW = 8'h80;
   localparam logic [7:0] COR_RSVD_OPT3_HIGH = 8'h07;
   localparam logic [7:0] COR_STAT_OPT2_HIGH = 8'h0C;
   // =====================================================
   // field positions
   localparam int COR_B_EXT_LIMIT = 7;
   localparam int COR_B_MON_DIR = 6;
   localparam int COR_B_Q2_THR = 5;
   localparam int COR_B_RSVD2 = 4;
   localparam int COR_B_AOC_EN = 3;
   localparam int COR_B_AOC_THR = 2;
   localparam int COR_B_BOC_EN = 1;
   localparam int COR_B_BOC_THR = 0;
   localparam int COR_B_PK_OVLD_T = 6;
   localparam int COR_B_PK_INPUT_CURRENT_REGULATION = 5;
   localparam int COR_B_PK_VSYS = 4;
   localparam int COR_B_PK_OVLD = 3;
   localparam int COR_B_PK_RELAX = 2;
   localparam int COR_B_PK_TOTAL = 0;
   localparam int COR_B_RSVD3 = 7;
   localparam int COR_B_CON_HOT = 6;
   localparam int COR_B_PIN_FUNC = 5;
   localparam int COR_B_CLAMP = 3;
   localparam int COR_B_LOW_RANGE = 2;
   localparam int COR_B_BSW_OFF = 1;
   localparam int COR_B_SYSTEM_POWER_MONITOR_SRC = 0;
   localparam logic [1:0] COR_CLAMP_OFF = 2'h3;
   // interrupt status and mask layout
   localparam int COR_IRQ_OVLD = 0;
   localparam int COR_IRQ_RELAX = 1;
   localparam int COR_IRQ_HOT = 2;
   localparam int COR_IRQ_W = 3;
   localparam logic [COR_IRQ_W-1:0] COR_RST_IRQ = 3'h0;
   // =====================================================
   // timing: peak power cycle lengths in ms
   localparam int COR_CLK_HZ = 10_000_000;
   localparam int COR_MS_PER_S = 1000;
   localparam int COR_MS_CYCLES = COR_CLK_HZ / COR_MS_PER_S;
   localparam logic [5:0] COR_OVLD_MS0 = 6'd1;
   localparam logic [5:0] COR_OVLD_MS1 = 6'd2;
   localparam logic [5:0] COR_OVLD_MS2 = 6'd10;
   localparam logic [5:0] COR_OVLD_MS3 = 6'd20;
   localparam logic [5:0] COR_TOTAL_MS0 = 6'd5;
   localparam logic [5:0] COR_TOTAL_MS1 = 6'd10;
   localparam logic [5:0] COR_TOTAL_MS2 = 6'd20;
   localparam logic [5:0] COR_TOTAL_MS3 = 6'd40;
   typedef enum logic [1:0] {COR_PK_IDLE, COR_PK_OVLD, COR_PK_RELAX} cor_peak_state_t;
endpackage

/* File: logic/cor_sync3.sv */
// three-stage synchroniser for comparator and pin levels
// assumes inputs are asynchronous levels; a change counts once stages two and three agree
`timescale 1ns/1ns
module cor_sync3 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   // =====================================================
   // stage one feeds only stage two, to keep metastability contained
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         sync_out <= '0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            sync_out <= s3;
         end
      end
   end
endmodule

/* File: logic/cor_peak_timer.sv */
// peak power cycle sequencer: overload phase then relax phase inside one total period
// assumes trigger is already synchronous; ms tick length is a parameter
`timescale 1ns/1ns
module cor_peak_timer
   import cor_pkg::*;
#(
   parameter int MS_CYCLES = COR_MS_CYCLES
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic trigger,
   input wire logic [1:0] ovld_sel,
   input wire logic [1:0] total_sel,
   output logic in_overload,
   output logic in_relax
);
   localparam int PW = $clog2(MS_CYCLES + 1);
   localparam logic [PW-1:0] PRESC_LAST = PW'(MS_CYCLES - 1);
   cor_peak_state_t state;
   logic [PW-1:0] presc;
   logic [5:0] ms_done;
   logic [5:0] ovld_ms;
   logic [5:0] total_ms;
   logic tick;
   // =====================================================
   // phase lengths from the selection fields
   always_comb begin
      case (ovld_sel)
         2'h0: ovld_ms = COR_OVLD_MS0;
         2'h1: ovld_ms = COR_OVLD_MS1;
         2'h2: ovld_ms = COR_OVLD_MS2;
         default: ovld_ms = COR_OVLD_MS3;
      endcase
      case (total_sel)
         2'h0: total_ms = COR_TOTAL_MS0;
         2'h1: total_ms = COR_TOTAL_MS1;
         2'h2: total_ms = COR_TOTAL_MS2;
         default: total_ms = COR_TOTAL_MS3;
      endcase
   end
   assign tick = (presc == PRESC_LAST);
   // =====================================================
   // phase sequencer; an overload as long as the total or longer skips relax
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= COR_PK_IDLE;
         presc <= '0;
         ms_done <= 6'd0;
      end else begin
         presc <= (tick || state == COR_PK_IDLE) ? '0 : presc + 1'b1;
         if (tick) begin
            ms_done <= ms_done + 6'd1;
         end
         case (state)
            COR_PK_IDLE: begin
               ms_done <= 6'd0;
               if (trigger) begin
                  state <= COR_PK_OVLD;
               end
            end
            COR_PK_OVLD: begin
               if (tick && ms_done + 6'd1 >= ovld_ms) begin
                  state <= (ms_done + 6'd1 >= total_ms) ? COR_PK_IDLE : COR_PK_RELAX;
               end
            end
            COR_PK_RELAX: begin
               if (tick && ms_done + 6'd1 >= total_ms) begin
                  state <= COR_PK_IDLE;
               end
            end
            default: state <= COR_PK_IDLE;
         endcase
      end
   end
   assign in_overload = (state == COR_PK_OVLD);
   assign in_relax = (state == COR_PK_RELAX);
endmodule

/* File: logic/cor_regs.sv */
// charger option configuration and status registers behind an APB slave
// assumes comparator inputs are asynchronous pins and the rest share CLK
//
// Behaviour
// - ext limit bit set: input limit is lower of register and pin; clear: register only
// - monitor direction bit: 0 reports discharge current, 1 charge current
// - second switch overcurrent threshold bit: 0 is 210mV, 1 is 150mV
// - adapter overcurrent enable, threshold 133 or 200 percent of second limit
// - battery overcurrent enable, threshold 133 or 200 percent of discharge setting
// - overload cycle time field: 1, 2, 10 or 20 ms
// - input regulation may start peak power mode when enabled
// - low system voltage may start peak power mode when enabled
// - overload status bit reads 1 while in overload cycle
// - relax status bit reads 1 while in relax cycle
// - total peak cycle time field: 5, 10, 20 or 40 ms
// - conservative trigger: hot output when rail below 3.2V and system below threshold
// - reverse pin function: 0 assist mode enable, 1 reverse output enable
// - average inductor clamp field: 6A, 10A, 15A or off
// - reverse output offset bit: 0 is 4.28V range, 1 is 3V range
// - battery switch in high impedance mode: 0 stays on, 1 turns off
// - power monitor in reverse mode: 0 system power, 1 battery discharge power
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
module cor_regs
   import cor_pkg::*;
#(
   parameter int MS_CYCLES = COR_MS_CYCLES
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic [9:0] PADDR,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [7:0] INPUT_LIMIT_SETTING,
   input wire logic [7:0] INPUT_LIMIT_PIN_CODE,
   input wire logic HIGH_IMPEDANCE_MODE,
   input wire logic REVERSE_OUTPUT_ACTIVE,
   input wire logic INPUT_CURRENT_REGULATION,
   input wire logic SYSTEM_VOLTAGE_LOW,
   input wire logic INPUT_RAIL_LOW,
   input wire logic SYSTEM_BELOW_FIRST_THRESHOLD,
   input wire logic REVERSE_PIN,
   output logic [7:0] EFFECTIVE_INPUT_LIMIT,
   output logic BATTERY_MONITOR_DIRECTION,
   output logic SECOND_SWITCH_OVERCURRENT_THRESHOLD,
   output logic ADAPTER_OVERCURRENT_ENABLE,
   output logic ADAPTER_OVERCURRENT_THRESHOLD,
   output logic BATTERY_OVERCURRENT_ENABLE,
   output logic BATTERY_OVERCURRENT_THRESHOLD,
   output logic [1:0] PEAK_OVERLOAD_TIME,
   output logic [1:0] PEAK_CYCLE_TOTAL_TIME,
   output logic PEAK_OVERLOAD_STATUS,
   output logic PEAK_RELAX_STATUS,
   output logic HOT_REQUEST,
   output logic REVERSE_OUTPUT_MODE_ENABLE,
   output logic MINIMUM_VOLTAGE_ASSIST_ENABLE,
   output logic [1:0] INDUCTOR_AVERAGE_CLAMP,
   output logic INDUCTOR_CLAMP_ACTIVE,
   output logic REVERSE_OUTPUT_LOW_RANGE,
   output logic BATTERY_SWITCH_ON,
   output logic POWER_MONITOR_REVERSE_SOURCE,
   output logic IRQ
);
   // =====================================================
   // storage
   logic [7:0] opt2_low;
   logic [7:0] opt2_high;
   logic [7:0] opt3_low;
   logic [7:0] opt3_high;
   logic [COR_IRQ_W-1:0] irq_status;
   logic [COR_IRQ_W-1:0] irq_mask;
   logic [4:0] pins_sync;
   logic in_reg_s;
   logic sys_low_s;
   logic rail_low_s;
   logic below_th1_s;
   logic rev_pin_s;
   logic peak_trigger;
   logic in_overload;
   logic in_relax;
   logic hot_cond;
   logic [COR_IRQ_W-1:0] irq_event;

   // =====================================================
   // bus decode
   logic setup_ok;
   logic wr_fire;
   logic lane0;
   logic [7:0] idx;
   logic mapped;
   logic [31:0] next_rdata;
   assign idx = PADDR[9:2];
   assign setup_ok = PSEL && PENABLE && !PREADY;
   assign wr_fire = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
   assign lane0 = PSTRB[0];
   // every access waits one cycle; unmapped or misaligned addresses answer with error
   always_comb begin
      mapped = (PADDR[1:0] == 2'h0);
      next_rdata = 32'h0000_0000;
      case (idx)
         COR_IDX_OPT2_LOW: next_rdata[7:0] = opt2_low;
         COR_IDX_OPT2_HIGH: begin
            next_rdata[7:0] = opt2_high;
            next_rdata[COR_B_PK_OVLD] = PEAK_OVERLOAD_STATUS;
            next_rdata[COR_B_PK_RELAX] = PEAK_RELAX_STATUS;
         end
         COR_IDX_OPT3_LOW: next_rdata[7:0] = opt3_low;
         COR_IDX_OPT3_HIGH: next_rdata[7:0] = opt3_high;
         COR_IDX_IRQ_STATUS: next_rdata[COR_IRQ_W-1:0] = irq_status;
         COR_IDX_IRQ_MASK: next_rdata[COR_IRQ_W-1:0] = irq_mask;
         default: mapped = 1'b0;
      endcase
   end

   // =====================================================
   // apb answer: pready one cycle into the access phase
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0000_0000;
      end else begin
         PREADY <= setup_ok;
         PSLVERR <= setup_ok && !mapped;
         if (setup_ok && !PWRITE && mapped) begin
            PRDATA <= next_rdata;
         end
      end
   end

   // =====================================================
   // configuration bytes; reserved and status bits never take bus data
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         opt2_low <= COR_RST_OPT2_LOW;
         opt2_high <= COR_RST_OPT2_HIGH;
         opt3_low <= COR_RST_OPT3_LOW;
         opt3_high <= COR_RST_OPT3_HIGH;
      end else if (wr_fire && lane0) begin
         case (idx)
            COR_IDX_OPT2_LOW: begin
               // reserved bit kept at its value even if software misbehaves
               opt2_low <= (PWDATA[7:0] & ~COR_RSVD_OPT2_LOW) | COR_RSVD_OPT2_LOW;
            end
            COR_IDX_OPT2_HIGH: begin
               opt2_high <= PWDATA[7:0] & ~COR_STAT_OPT2_HIGH;
            end
            COR_IDX_OPT3_LOW: begin
               opt3_low <= PWDATA[7:0] & ~COR_RSVD_OPT3_LOW;
            end
            COR_IDX_OPT3_HIGH: begin
               opt3_high <= PWDATA[7:0] & ~COR_RSVD_OPT3_HIGH;
            end
            default: opt2_low <= opt2_low;
         endcase
      end
   end

   // =====================================================
   // asynchronous comparator and pin levels
   cor_sync3 #(
      .W(5)
   ) u_sync (
      .clk(CLK),
      .arst_n(ARST_N),
      .async_in({INPUT_CURRENT_REGULATION, SYSTEM_VOLTAGE_LOW, INPUT_RAIL_LOW,
                 SYSTEM_BELOW_FIRST_THRESHOLD, REVERSE_PIN}),
      .sync_out(pins_sync)
   );
   assign in_reg_s = pins_sync[4];
   assign sys_low_s = pins_sync[3];
   assign rail_low_s = pins_sync[2];
   assign below_th1_s = pins_sync[1];
   assign rev_pin_s = pins_sync[0];

   // =====================================================
   // peak power mode
   assign peak_trigger = (opt2_high[COR_B_PK_INPUT_CURRENT_REGULATION] && in_reg_s)
      || (opt2_high[COR_B_PK_VSYS] && sys_low_s);
   cor_peak_timer #(
      .MS_CYCLES(MS_CYCLES)
   ) u_peak (
      .clk(CLK),
      .arst_n(ARST_N),
      .trigger(peak_trigger),
      .ovld_sel(opt2_high[COR_B_PK_OVLD_T +: 2]),
      .total_sel(opt2_high[COR_B_PK_TOTAL +: 2]),
      .in_overload(in_overload),
      .in_relax(in_relax)
   );

   // =====================================================
   // derived controls, all registered so outputs come from flops
   assign hot_cond = opt3_low[COR_B_CON_HOT] && rail_low_s && below_th1_s;
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         EFFECTIVE_INPUT_LIMIT <= 8'h00;
         PEAK_OVERLOAD_STATUS <= 1'b0;
         PEAK_RELAX_STATUS <= 1'b0;
         HOT_REQUEST <= 1'b0;
         REVERSE_OUTPUT_MODE_ENABLE <= 1'b0;
         MINIMUM_VOLTAGE_ASSIST_ENABLE <= 1'b0;
         BATTERY_SWITCH_ON <= 1'b1;
         POWER_MONITOR_REVERSE_SOURCE <= 1'b0;
      end else begin
         // pin clamps the limit only when it is lower
         if (opt2_low[COR_B_EXT_LIMIT] && INPUT_LIMIT_PIN_CODE < INPUT_LIMIT_SETTING) begin
            EFFECTIVE_INPUT_LIMIT <= INPUT_LIMIT_PIN_CODE;
         end else begin
            EFFECTIVE_INPUT_LIMIT <= INPUT_LIMIT_SETTING;
         end
         PEAK_OVERLOAD_STATUS <= in_overload;
         PEAK_RELAX_STATUS <= in_relax;
         HOT_REQUEST <= hot_cond;
         // one pin, two meanings
         REVERSE_OUTPUT_MODE_ENABLE <= rev_pin_s && opt3_low[COR_B_PIN_FUNC];
         MINIMUM_VOLTAGE_ASSIST_ENABLE <= rev_pin_s && !opt3_low[COR_B_PIN_FUNC];
         BATTERY_SWITCH_ON <= !(HIGH_IMPEDANCE_MODE && opt3_low[COR_B_BSW_OFF]);
         // source choice matters only during reverse mode
         POWER_MONITOR_REVERSE_SOURCE <= REVERSE_OUTPUT_ACTIVE && opt3_low[COR_B_SYSTEM_POWER_MONITOR_SRC];
      end
   end

   // =====================================================
   // plain field outputs straight from the register flops
   assign BATTERY_MONITOR_DIRECTION = opt2_low[COR_B_MON_DIR];
   assign SECOND_SWITCH_OVERCURRENT_THRESHOLD = opt2_low[COR_B_Q2_THR];
   assign ADAPTER_OVERCURRENT_ENABLE = opt2_low[COR_B_AOC_EN];
   assign ADAPTER_OVERCURRENT_THRESHOLD = opt2_low[COR_B_AOC_THR];
   assign BATTERY_OVERCURRENT_ENABLE = opt2_low[COR_B_BOC_EN];
   assign BATTERY_OVERCURRENT_THRESHOLD = opt2_low[COR_B_BOC_THR];
   assign PEAK_OVERLOAD_TIME = opt2_high[COR_B_PK_OVLD_T +: 2];
   assign PEAK_CYCLE_TOTAL_TIME = opt2_high[COR_B_PK_TOTAL +: 2];
   assign INDUCTOR_AVERAGE_CLAMP = opt3_low[COR_B_CLAMP +: 2];
   assign REVERSE_OUTPUT_LOW_RANGE = opt3_low[COR_B_LOW_RANGE];
   // clamp code 11 turns the clamp off
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         INDUCTOR_CLAMP_ACTIVE <= 1'b0;
      end else begin
         INDUCTOR_CLAMP_ACTIVE <= (opt3_low[COR_B_CLAMP +: 2] != COR_CLAMP_OFF);
      end
   end

   // =====================================================
   // interrupts: rising edges of cycle phases and hot request
   assign irq_event[COR_IRQ_OVLD] = in_overload && !PEAK_OVERLOAD_STATUS;
   assign irq_event[COR_IRQ_RELAX] = in_relax && !PEAK_RELAX_STATUS;
   assign irq_event[COR_IRQ_HOT] = hot_cond && !HOT_REQUEST;
   // write one to clear; a new event in the clearing cycle wins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_status <= COR_RST_IRQ;
         irq_mask <= COR_RST_IRQ;
         IRQ <= 1'b0;
      end else begin
         if (wr_fire && lane0 && idx == COR_IDX_IRQ_STATUS) begin
            irq_status <= (irq_status & ~PWDATA[COR_IRQ_W-1:0]) | irq_event;
         end else begin
            irq_status <= irq_status | irq_event;
         end
         if (wr_fire && lane0 && idx == COR_IDX_IRQ_MASK) begin
            irq_mask <= PWDATA[COR_IRQ_W-1:0];
         end
         IRQ <= |(irq_status & irq_mask);
      end
   end

   // =====================================================
   // checks
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!ARST_N);

   sequence wr_opt2_low_s;
      wr_fire && lane0 && idx == COR_IDX_OPT2_LOW;
   endsequence
   sequence wr_opt2_high_s;
      wr_fire && lane0 && idx == COR_IDX_OPT2_HIGH;
   endsequence

   // antecedent waits for a settled reset, so the edge of release is not judged
   ext_limit_a: assert property (ARST_N |=> EFFECTIVE_INPUT_LIMIT ==
      (($past(opt2_low[COR_B_EXT_LIMIT]) &&
        $past(INPUT_LIMIT_PIN_CODE) < $past(INPUT_LIMIT_SETTING)) ?
       $past(INPUT_LIMIT_PIN_CODE) : $past(INPUT_LIMIT_SETTING)))
      else $error("effective input limit wrong");
   mon_dir_a: assert property (wr_opt2_low_s |=>
      BATTERY_MONITOR_DIRECTION == $past(PWDATA[COR_B_MON_DIR]))
      else $error("monitor direction not written");
   q2_thr_a: assert property (wr_opt2_low_s |=>
      SECOND_SWITCH_OVERCURRENT_THRESHOLD == $past(PWDATA[COR_B_Q2_THR]))
      else $error("switch threshold not written");
   rsvd_keep_a: assert property (opt2_low[COR_B_RSVD2] && !opt3_low[COR_B_RSVD3])
      else $error("reserved bit changed");
   adapter_oc_a: assert property (wr_opt2_low_s |=>
      {ADAPTER_OVERCURRENT_ENABLE, ADAPTER_OVERCURRENT_THRESHOLD} ==
      $past(PWDATA[COR_B_AOC_THR +: 2]))
      else $error("adapter overcurrent fields wrong");
   battery_oc_a: assert property (wr_opt2_low_s |=>
      {BATTERY_OVERCURRENT_ENABLE, BATTERY_OVERCURRENT_THRESHOLD} ==
      $past(PWDATA[COR_B_BOC_THR +: 2]))
      else $error("battery overcurrent fields wrong");
   peak_start_a: assert property ($rose(PEAK_OVERLOAD_STATUS) |->
      $past(peak_trigger, 2))
      else $error("peak cycle started without trigger");
   phase_excl_a: assert property (!(PEAK_OVERLOAD_STATUS && PEAK_RELAX_STATUS))
      else $error("overload and relax both reported");
   relax_order_a: assert property ($rose(PEAK_RELAX_STATUS) |->
      $past(PEAK_OVERLOAD_STATUS))
      else $error("relax did not follow overload");
   stat_hold_a: assert property (wr_opt2_high_s |=>
      (opt2_high & COR_STAT_OPT2_HIGH) == 8'h00)
      else $error("software reached a status bit");
   hot_req_a: assert property (ARST_N |=> HOT_REQUEST == ($past(opt3_low[COR_B_CON_HOT])
      && $past(rail_low_s) && $past(below_th1_s)))
      else $error("hot request wrong");
   bat_switch_a: assert property (ARST_N |=> BATTERY_SWITCH_ON ==
      !($past(HIGH_IMPEDANCE_MODE) && $past(opt3_low[COR_B_BSW_OFF])))
      else $error("battery switch control wrong");
   apb_wait_a: assert property (setup_ok |=> PREADY ##1 !PREADY)
      else $error("apb answer timing wrong");
endmodule

/* File: verification/charger_option_config_regs_tb.sv */
// testbench for the charger option register group, driven over APB
// assumes the register block alone at 10 MHz with a shortened millisecond tick
`timescale 1ns/1ns
module charger_option_config_regs_tb
   import cor_pkg::*;
;
   // =====================================================
   // signals
   localparam int MS = 4;
   logic CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
   logic [9:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic [3:0] PSTRB;
   logic [7:0] INPUT_LIMIT_SETTING, INPUT_LIMIT_PIN_CODE, EFFECTIVE_INPUT_LIMIT;
   logic HIGH_IMPEDANCE_MODE, REVERSE_OUTPUT_ACTIVE, INPUT_CURRENT_REGULATION;
   logic SYSTEM_VOLTAGE_LOW, INPUT_RAIL_LOW, SYSTEM_BELOW_FIRST_THRESHOLD, REVERSE_PIN;
   logic BATTERY_MONITOR_DIRECTION, SECOND_SWITCH_OVERCURRENT_THRESHOLD;
   logic ADAPTER_OVERCURRENT_ENABLE, ADAPTER_OVERCURRENT_THRESHOLD;
   logic BATTERY_OVERCURRENT_ENABLE, BATTERY_OVERCURRENT_THRESHOLD;
   logic [1:0] PEAK_OVERLOAD_TIME, PEAK_CYCLE_TOTAL_TIME, INDUCTOR_AVERAGE_CLAMP;
   logic PEAK_OVERLOAD_STATUS, PEAK_RELAX_STATUS, HOT_REQUEST, REVERSE_OUTPUT_MODE_ENABLE;
   logic MINIMUM_VOLTAGE_ASSIST_ENABLE, INDUCTOR_CLAMP_ACTIVE, REVERSE_OUTPUT_LOW_RANGE;
   logic BATTERY_SWITCH_ON, POWER_MONITOR_REVERSE_SOURCE;
   logic [31:0] r;
   logic e;
   int num_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;

   // small tick so a full 40 ms cycle stays short
   cor_regs #(.MS_CYCLES(MS)) uut (.*);

   // =====================================================
   // helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         $display("ERROR t=%0h got=%h exp=%h", $time, got, exp);
         num_errors++;
      end
   endtask

   // one APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= {idx, 2'b00};
      PWDATA <= {24'h00_0000, d};
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(r, exp);
   endtask

   // peak cycle: raise triggers, measure overload and relax lengths in cycles
   task automatic peak_run(input logic [7:0] cfg, input logic [1:0] trig, input int ovl,
                           input int rlx);
      apb(1'b1, COR_IDX_OPT2_HIGH, cfg);
      {INPUT_CURRENT_REGULATION, SYSTEM_VOLTAGE_LOW} <= trig;
      n = 0;
      while (PEAK_OVERLOAD_STATUS !== 1'b1 && n < 30) begin
         @(posedge CLK);
         n++;
      end
      {INPUT_CURRENT_REGULATION, SYSTEM_VOLTAGE_LOW} <= 2'b00;
      n = 0;
      while (PEAK_OVERLOAD_STATUS === 1'b1) begin
         @(posedge CLK);
         n++;
      end
      chk(n, ovl);
      n = 0;
      while (PEAK_RELAX_STATUS === 1'b1) begin
         @(posedge CLK);
         n++;
      end
      chk(n, rlx);
      repeat (8) @(posedge CLK);
   endtask

   task automatic wrap_up();
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // =====================================================
   // clock and hang guard
   initial begin
      CLK = 1'b0;
      forever #50 CLK = ~CLK;
   end

   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         num_errors++;
         wrap_up();
      end
   end

   // =====================================================
   // main sequence
   initial begin
      {ARST_N, PSEL, PENABLE, PWRITE, INPUT_CURRENT_REGULATION, SYSTEM_VOLTAGE_LOW,
       INPUT_RAIL_LOW, SYSTEM_BELOW_FIRST_THRESHOLD} = '0;
      {PADDR, PWDATA, PSTRB} = {10'h000, 32'h0000_0000, 4'hF};
      {INPUT_LIMIT_SETTING, INPUT_LIMIT_PIN_CODE} = {8'h40, 8'h20};
      {HIGH_IMPEDANCE_MODE, REVERSE_OUTPUT_ACTIVE, REVERSE_PIN} = 3'h7;
      repeat (2) @(posedge CLK);
      ARST_N <= 1'b1;
      // the limit flop first computes on the edge after release
      repeat (2) @(posedge CLK);
      chk(EFFECTIVE_INPUT_LIMIT, 8'h20);
      chk({BATTERY_MONITOR_DIRECTION, SECOND_SWITCH_OVERCURRENT_THRESHOLD,
           ADAPTER_OVERCURRENT_ENABLE, ADAPTER_OVERCURRENT_THRESHOLD, BATTERY_OVERCURRENT_ENABLE,
           BATTERY_OVERCURRENT_THRESHOLD}, 6'h17);
      rd(COR_IDX_OPT2_LOW, 32'h0000_00B7);
      rd(COR_IDX_OPT2_HIGH, 32'h0000_0002);
      rd(COR_IDX_OPT3_LOW, 32'h0000_0030);
      rd(COR_IDX_OPT3_HIGH, 32'h0000_0000);
      // software write to the low option byte reads back and drives its field outputs
      apb(1'b1, COR_IDX_OPT2_LOW, 8'h58);
      rd(COR_IDX_OPT2_LOW, 32'h0000_0058);
      chk(EFFECTIVE_INPUT_LIMIT, 8'h40);
      chk({BATTERY_MONITOR_DIRECTION, SECOND_SWITCH_OVERCURRENT_THRESHOLD,
           ADAPTER_OVERCURRENT_ENABLE, ADAPTER_OVERCURRENT_THRESHOLD, BATTERY_OVERCURRENT_ENABLE,
           BATTERY_OVERCURRENT_THRESHOLD}, 6'h28);
      // status bits written as ones must not read back
      apb(1'b1, COR_IDX_OPT2_HIGH, 8'hCD);
      rd(COR_IDX_OPT2_HIGH, 32'h0000_00C1);
      chk({PEAK_OVERLOAD_TIME, PEAK_CYCLE_TOTAL_TIME}, 4'hD);
      apb(1'b1, COR_IDX_OPT3_HIGH, 8'hF8);
      rd(COR_IDX_OPT3_HIGH, 32'h0000_00F8);
      apb(1'b0, 8'h3F, 8'h00);
      chk(e, 1'b1);
      chk({REVERSE_OUTPUT_MODE_ENABLE, MINIMUM_VOLTAGE_ASSIST_ENABLE, INDUCTOR_AVERAGE_CLAMP,
           INDUCTOR_CLAMP_ACTIVE, REVERSE_OUTPUT_LOW_RANGE, BATTERY_SWITCH_ON,
           POWER_MONITOR_REVERSE_SOURCE}, 8'hAA);
      apb(1'b1, COR_IDX_OPT3_LOW, 8'h1F);
      rd(COR_IDX_OPT3_LOW, 32'h0000_001F);
      chk({REVERSE_OUTPUT_MODE_ENABLE, MINIMUM_VOLTAGE_ASSIST_ENABLE, INDUCTOR_AVERAGE_CLAMP,
           INDUCTOR_CLAMP_ACTIVE, REVERSE_OUTPUT_LOW_RANGE, BATTERY_SWITCH_ON,
           POWER_MONITOR_REVERSE_SOURCE}, 8'h75);
      // hot request only while enabled and both comparators low
      {INPUT_RAIL_LOW, SYSTEM_BELOW_FIRST_THRESHOLD} <= 2'b11;
      repeat (8) @(posedge CLK);
      chk(HOT_REQUEST, 1'b0);
      apb(1'b1, COR_IDX_OPT3_LOW, 8'h40);
      repeat (3) @(posedge CLK);
      chk(HOT_REQUEST, 1'b1);
      SYSTEM_BELOW_FIRST_THRESHOLD <= 1'b0;
      repeat (8) @(posedge CLK);
      chk(HOT_REQUEST, 1'b0);
      peak_run(8'h20, 2'b10, MS * 1, MS * 4);
      peak_run(8'h50, 2'b10, 0, 0);
      peak_run(8'h50, 2'b01, MS * 2, MS * 3);
      peak_run(8'hA1, 2'b10, MS * 10, 0);
      // interrupt: raised, masked, then cleared by writing ones
      apb(1'b1, COR_IDX_IRQ_MASK, 8'h07);
      rd(COR_IDX_IRQ_STATUS, 32'h0000_0007);
      chk(IRQ, 1'b1);
      apb(1'b1, COR_IDX_IRQ_MASK, 8'h00);
      repeat (2) @(posedge CLK);
      chk(IRQ, 1'b0);
      apb(1'b1, COR_IDX_IRQ_STATUS, 8'h07);
      rd(COR_IDX_IRQ_STATUS, 32'h0000_0000);
      wrap_up();
   end
endmodule
